// ==== rtl/sci_pkg.sv ====
// shared constants and carrier types of the card interrupt enable block
//
// Notes on behaviour
// - one writable 8-bit enable register; an event interrupts only while enabled.
// - bit 7 enables the transmit buffer empty interrupt while buffer empty.
// - bit 6 has no function, reads zero, writes ignored.
// - bit 5 enables the card supply current overload interrupt.
// - bit 4 enables the card supply voltage out of range interrupt.
// - bit 3 enables the waiting time counter underflow interrupt.
// - bit 2 enables the character transmitted interrupt.
// - bit 1 enables the character received interrupt.
// - bit 0 enables the parity error interrupt.
// - pending flag sets when enabled event occurs; reading pending clears flags.
package sci_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] OFS_ENABLES = 4'h0;
   localparam logic [3:0] OFS_PENDING = 4'h1;

   // ***************************************************************
   // field positions and values
   // ***************************************************************
   localparam int BIT_TX_EMPTY = 7;
   localparam int BIT_UNUSED = 6;
   localparam int BIT_OVERCURRENT = 5;
   localparam int BIT_VOLTAGE = 4;
   localparam int BIT_WAIT_TIMEOUT = 3;
   localparam int BIT_CHAR_SENT = 2;
   localparam int BIT_CHAR_RECEIVED = 1;
   localparam int BIT_PARITY = 0;
   localparam logic [7:0] IMPL_MASK = 8'hBF;
   localparam logic [7:0] RST_ENABLES = 8'h00;
   localparam logic [7:0] RST_PENDING = 8'h00;
   localparam logic [7:0] RST_RDATA = 8'h00;

   // ***************************************************************
   // carrier types
   // ***************************************************************
   // one bit for each event, laid out as the enable register
   typedef struct packed {
      logic tx_buffer_empty;
      logic unused;
      logic overcurrent;
      logic supply_voltage_fault;
      logic wait_timeout;
      logic char_sent;
      logic char_received;
      logic parity_fault;
   } sci_irq_bits_t;

   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sci_bus_req_t;

endpackage

// ==== rtl/sci_irq_enable.sv ====
// card interface interrupt enable, pending flags and interrupt output
//
// The implementer's own choices: the strobed register port and the address map.
module sci_irq_enable (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // register port
   input wire sci_pkg::sci_bus_req_t bus,
   output logic [7:0] rdata,
   // event sources, same clock domain
   input wire sci_pkg::sci_irq_bits_t events,
   // interrupt to the core
   output logic irq
);

   // ***************************************************************
   // decode
   // ***************************************************************
   logic [7:0] enables_q;
   logic [7:0] pending_q;
   logic [7:0] pending_d;
   logic [7:0] rdata_q;
   logic [7:0] event_v;
   logic [7:0] set_v;
   logic wr_enables;
   logic wr_pending;
   logic rd_pending;

   // address match helper, used by every strobe decode
   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction

   assign wr_enables = bus.wr && hit(bus.addr, sci_pkg::OFS_ENABLES);
   assign wr_pending = bus.wr && hit(bus.addr, sci_pkg::OFS_PENDING);
   assign rd_pending = bus.rd && hit(bus.addr, sci_pkg::OFS_PENDING);

   // bit 6 carries no event, so it is forced out of the vector
   assign event_v = events & sci_pkg::IMPL_MASK;
   // only enabled events may set a flag
   assign set_v = event_v & enables_q;

   // ***************************************************************
   // enable register
   // ***************************************************************
   // unimplemented bit is dropped at the write so it always reads zero
   always_ff @(posedge clock) begin
      if (reset) begin
         enables_q <= sci_pkg::RST_ENABLES;
      end else if (wr_enables) begin
         enables_q <= bus.wdata & sci_pkg::IMPL_MASK;
      end
   end

   // ***************************************************************
   // pending flags
   // ***************************************************************
   // read clears, a written one also clears; a new set wins over both so
   // an event landing in the clearing cycle is never lost
   always_comb begin
      pending_d = pending_q;
      if (rd_pending) begin
         pending_d = 8'h00;
      end
      if (wr_pending) begin
         pending_d = pending_d & ~bus.wdata;
      end
      pending_d = pending_d | set_v;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         pending_q <= sci_pkg::RST_PENDING;
      end else begin
         pending_q <= pending_d;
      end
   end

   // ***************************************************************
   // read data
   // ***************************************************************
   // registered, valid only in the cycle after the read strobe;
   // unmapped addresses and idle cycles answer zero
   always_ff @(posedge clock) begin
      if (reset) begin
         rdata_q <= sci_pkg::RST_RDATA;
      end else if (bus.rd && hit(bus.addr, sci_pkg::OFS_ENABLES)) begin
         rdata_q <= enables_q;
      end else if (rd_pending) begin
         rdata_q <= pending_q;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata = rdata_q;

   // level interrupt; the enable doubles as mask so a flag whose enable
   // was dropped after setting no longer asserts the line
   assign irq = |(pending_q & enables_q);

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   sequence s_pend_read;
      rd_pending && !(|set_v);
   endsequence

   sequence s_pend_empty;
      pending_q == 8'h00;
   endsequence

   property p_sets(int b);
      enables_q[b] && event_v[b] |=> pending_q[b];
   endproperty

   a_reset_disables: assert property (disable iff (1'b0)
      reset |=> enables_q == 8'h00 && !irq)
      else $error("enables not cleared by reset");

   a_enable_write: assert property (wr_enables |=>
      enables_q == ($past(bus.wdata) & sci_pkg::IMPL_MASK))
      else $error("enable write not stored");

   a_bit6_zero: assert property (!enables_q[6] && !pending_q[6]
      && !(rdata_q[6]))
      else $error("unused bit not zero");

   a_no_disabled_set: assert property (
      ((pending_q & ~$past(pending_q)) & ~$past(enables_q)) == 8'h00)
      else $error("flag set while disabled");

   a_tx_empty_sets: assert property (p_sets(7))
      else $error("tx empty flag missed");
   a_overcurrent_sets: assert property (p_sets(5))
      else $error("overcurrent flag missed");
   a_voltage_sets: assert property (p_sets(4))
      else $error("voltage flag missed");
   a_timeout_sets: assert property (p_sets(3))
      else $error("wait timeout flag missed");
   a_sent_sets: assert property (p_sets(2))
      else $error("char sent flag missed");
   a_received_sets: assert property (p_sets(1))
      else $error("char received flag missed");
   a_parity_sets: assert property (p_sets(0))
      else $error("parity flag missed");

   a_read_clears: assert property (s_pend_read |=> s_pend_empty)
      else $error("pending read did not clear");

   a_read_returns: assert property (rd_pending |=>
      rdata == $past(pending_q))
      else $error("pending read data wrong");

   a_irq_cause: assert property ($rose(irq) |->
      $past(|set_v) || $past(wr_enables))
      else $error("interrupt rose without cause");

   // ***************************************************************
   // register port and reset checks
   // ***************************************************************
   // sequences for the clear-versus-set clash, where the set must win
   sequence s_set_clash;
      (rd_pending || wr_pending) && (|set_v);
   endsequence

   sequence s_flag_kept;
      (pending_q & $past(set_v)) == $past(set_v);
   endsequence

   a_set_wins: assert property (s_set_clash |=> s_flag_kept)
      else $error("new flag lost in clearing cycle");

   // reset also empties the flags and the read register
   a_reset_flags: assert property (disable iff (1'b0)
      reset |=> pending_q == 8'h00 && rdata_q == 8'h00)
      else $error("flags not cleared by reset");

   // enables move only on a write to their own offset
   a_enables_hold: assert property (!wr_enables |=>
      $stable(enables_q))
      else $error("enables changed without a write");

   // reading the enables returns what was stored
   a_read_enables: assert property (
      bus.rd && hit(bus.addr, sci_pkg::OFS_ENABLES) |=>
      rdata == $past(enables_q))
      else $error("enable read data wrong");

   // rdata only carries a value in the cycle after a read strobe
   a_rdata_idle: assert property (!bus.rd |=> rdata == 8'h00)
      else $error("read data not zero when idle");

   // unmapped offsets answer zero so software sees no ghost register
   a_rdata_unmapped: assert property (bus.rd
      && !hit(bus.addr, sci_pkg::OFS_ENABLES) && !rd_pending |=>
      rdata == 8'h00)
      else $error("unmapped read not zero");

   // no enable at all means a quiet interrupt line
   a_irq_masked: assert property (!(|enables_q) |-> !irq)
      else $error("interrupt with every enable low");

   // the line only falls after a clear or an enable change
   a_irq_drop: assert property ($fell(irq) |->
      $past(rd_pending || wr_pending || wr_enables))
      else $error("interrupt fell without a clear");

   // the unused event input never leaves a trace
   a_unused_event: assert property (events.unused |=> !pending_q[6])
      else $error("unused event reached a flag");

   // ***************************************************************
   // per-bit checks, one instance for each implemented bit
   // ***************************************************************
   // a clear flag with its enable low stays clear whatever the event does
   property p_blocks(int b);
      !enables_q[b] && !pending_q[b] |=> !pending_q[b];
   endproperty

   // a set flag survives until a read or a written one clears it
   property p_holds(int b);
      pending_q[b] && !rd_pending && !(wr_pending && bus.wdata[b]) |=>
         pending_q[b];
   endproperty

   // a written one clears its flag unless the event is back in that cycle
   property p_w1c(int b);
      wr_pending && bus.wdata[b] && !(enables_q[b] && event_v[b]) |=>
         !pending_q[b];
   endproperty

   // a pending read clears the flag unless the event is back in that cycle
   property p_rd_clears(int b);
      rd_pending && !(enables_q[b] && event_v[b]) |=> !pending_q[b];
   endproperty

   // an enabled set flag always drives the interrupt line
   property p_irq_bit(int b);
      enables_q[b] && pending_q[b] |-> irq;
   endproperty

   // each written bit lands in its enable
   property p_en_bit(int b);
      wr_enables |=> enables_q[b] == $past(bus.wdata[b]);
   endproperty

   // disabled events are not remembered for later
   a_tx_empty_blocks: assert property (p_blocks(7))
      else $error("tx empty flag set while disabled");
   a_overcurrent_blocks: assert property (p_blocks(5))
      else $error("overcurrent flag set while disabled");
   a_voltage_blocks: assert property (p_blocks(4))
      else $error("voltage flag set while disabled");
   a_timeout_blocks: assert property (p_blocks(3))
      else $error("timeout flag set while disabled");
   a_sent_blocks: assert property (p_blocks(2))
      else $error("char sent flag set while disabled");
   a_received_blocks: assert property (p_blocks(1))
      else $error("char received flag set while disabled");
   a_parity_blocks: assert property (p_blocks(0))
      else $error("parity flag set while disabled");

   // flags are sticky
   a_tx_empty_holds: assert property (p_holds(7))
      else $error("tx empty flag lost");
   a_overcurrent_holds: assert property (p_holds(5))
      else $error("overcurrent flag lost");
   a_voltage_holds: assert property (p_holds(4))
      else $error("voltage flag lost");
   a_timeout_holds: assert property (p_holds(3))
      else $error("timeout flag lost");
   a_sent_holds: assert property (p_holds(2))
      else $error("char sent flag lost");
   a_received_holds: assert property (p_holds(1))
      else $error("char received flag lost");
   a_parity_holds: assert property (p_holds(0))
      else $error("parity flag lost");

   // written ones clear
   a_tx_empty_w1c: assert property (p_w1c(7))
      else $error("tx empty flag not cleared by write");
   a_overcurrent_w1c: assert property (p_w1c(5))
      else $error("overcurrent flag not cleared by write");
   a_voltage_w1c: assert property (p_w1c(4))
      else $error("voltage flag not cleared by write");
   a_timeout_w1c: assert property (p_w1c(3))
      else $error("timeout flag not cleared by write");
   a_sent_w1c: assert property (p_w1c(2))
      else $error("char sent flag not cleared by write");
   a_received_w1c: assert property (p_w1c(1))
      else $error("char received flag not cleared by write");
   a_parity_w1c: assert property (p_w1c(0))
      else $error("parity flag not cleared by write");

   // reads clear
   a_tx_empty_rdclr: assert property (p_rd_clears(7))
      else $error("tx empty flag not cleared by read");
   a_overcurrent_rdclr: assert property (p_rd_clears(5))
      else $error("overcurrent flag not cleared by read");
   a_voltage_rdclr: assert property (p_rd_clears(4))
      else $error("voltage flag not cleared by read");
   a_timeout_rdclr: assert property (p_rd_clears(3))
      else $error("timeout flag not cleared by read");
   a_sent_rdclr: assert property (p_rd_clears(2))
      else $error("char sent flag not cleared by read");
   a_received_rdclr: assert property (p_rd_clears(1))
      else $error("char received flag not cleared by read");
   a_parity_rdclr: assert property (p_rd_clears(0))
      else $error("parity flag not cleared by read");

   // enabled flags raise the line
   a_tx_empty_irq: assert property (p_irq_bit(7))
      else $error("tx empty flag without interrupt");
   a_overcurrent_irq: assert property (p_irq_bit(5))
      else $error("overcurrent flag without interrupt");
   a_voltage_irq: assert property (p_irq_bit(4))
      else $error("voltage flag without interrupt");
   a_timeout_irq: assert property (p_irq_bit(3))
      else $error("timeout flag without interrupt");
   a_sent_irq: assert property (p_irq_bit(2))
      else $error("char sent flag without interrupt");
   a_received_irq: assert property (p_irq_bit(1))
      else $error("char received flag without interrupt");
   a_parity_irq: assert property (p_irq_bit(0))
      else $error("parity flag without interrupt");

   // written enables land bit by bit
   a_tx_empty_en: assert property (p_en_bit(7))
      else $error("tx empty enable not stored");
   a_overcurrent_en: assert property (p_en_bit(5))
      else $error("overcurrent enable not stored");
   a_voltage_en: assert property (p_en_bit(4))
      else $error("voltage enable not stored");
   a_timeout_en: assert property (p_en_bit(3))
      else $error("timeout enable not stored");
   a_sent_en: assert property (p_en_bit(2))
      else $error("char sent enable not stored");
   a_received_en: assert property (p_en_bit(1))
      else $error("char received enable not stored");
   a_parity_en: assert property (p_en_bit(0))
      else $error("parity enable not stored");

endmodule

// ==== tb/sci_irq_enable_tb.sv ====
// self-checking bench of the card interrupt enable block
module sci_irq_enable_tb;
   timeunit 1ns;
   timeprecision 100ps;

   // ***************************************************************
   // clock, reset and design ports
   // ***************************************************************
   logic clock = 1'b0;
   logic reset = 1'b1;
   sci_pkg::sci_bus_req_t bus = '0;
   sci_pkg::sci_irq_bits_t events = '0;
   logic [7:0] rdata;
   logic irq;
   int err_total = 0;
   int total_checks = 0;

   // 40 MHz clock
   always #12.5 clock = ~clock;

   sci_irq_enable u_dut (
      .clock(clock),
      .reset(reset),
      .bus(bus),
      .rdata(rdata),
      .events(events),
      .irq(irq)
   );

   // ***************************************************************
   // report, compare and bus tasks
   // ***************************************************************
   // the only place where the run ends
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // four-state compare so an unknown never passes
   task automatic check(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what,
                  got, exp);
      end
   endtask

   // one-cycle write strobe
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus.wr <= 1'b0;
      #1;
   endtask

   // read data only stands in the cycle after the strobe, sample it there
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   // one-cycle event pulse, returns after the latching edge has landed
   task automatic pulse(input logic [7:0] v);
      @(posedge clock);
      events <= v;
      @(posedge clock);
      events <= 8'h00;
      #1;
   endtask

   // ***************************************************************
   // main sequence and hang guard
   // ***************************************************************
   initial begin
      logic [7:0] d;
      logic [7:0] m;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      rd_reg(sci_pkg::OFS_ENABLES, d);
      check(d, 8'h00, "enables after reset");
      rd_reg(sci_pkg::OFS_PENDING, d);
      check(d, 8'h00, "pending after reset");
      wr_reg(sci_pkg::OFS_ENABLES, 8'hFF);
      rd_reg(sci_pkg::OFS_ENABLES, d);
      check(d, 8'hBF, "enables readback");
      // one enable at a time while every event fires together
      for (int b = 0; b < 8; b++) begin
         m = 8'h01 << b;
         wr_reg(sci_pkg::OFS_ENABLES, m);
         pulse(8'hFF);
         check({7'h00, irq}, {7'h00, b != 6}, "irq");
         rd_reg(sci_pkg::OFS_PENDING, d);
         check(d, m & 8'hBF, "pending");
         rd_reg(sci_pkg::OFS_PENDING, d);
         check(d, 8'h00, "pending after read");
         check({7'h00, irq}, 8'h00, "irq after read");
      end
      // disabled events must not be remembered for later
      wr_reg(sci_pkg::OFS_ENABLES, 8'h00);
      pulse(8'hFF);
      check({7'h00, irq}, 8'h00, "irq disabled");
      wr_reg(sci_pkg::OFS_ENABLES, 8'hBF);
      rd_reg(sci_pkg::OFS_PENDING, d);
      check(d, 8'h00, "no stale pending");
      // written ones clear only the chosen flags
      wr_reg(sci_pkg::OFS_ENABLES, 8'h05);
      pulse(8'h05);
      wr_reg(sci_pkg::OFS_PENDING, 8'h01);
      rd_reg(sci_pkg::OFS_PENDING, d);
      check(d, 8'h04, "pending after write one");
      // the enable masks a standing flag
      pulse(8'h04);
      wr_reg(sci_pkg::OFS_ENABLES, 8'h00);
      check({7'h00, irq}, 8'h00, "irq masked");
      wr_reg(sci_pkg::OFS_ENABLES, 8'h04);
      check({7'h00, irq}, 8'h01, "irq unmasked");
      rd_reg(sci_pkg::OFS_PENDING, d);
      check(d, 8'h04, "masked flag kept");
      // an event in the read cycle survives the read
      wr_reg(sci_pkg::OFS_ENABLES, 8'h01);
      @(posedge clock);
      events <= 8'h01;
      rd_reg(sci_pkg::OFS_PENDING, d);
      check(d, 8'h01, "set during read");
      @(posedge clock);
      events <= 8'h00;
      rd_reg(sci_pkg::OFS_PENDING, d);
      check(d, 8'h01, "set wins over read");
      rd_reg(sci_pkg::OFS_PENDING, d);
      check(d, 8'h00, "cleared after event");
      // reset in mid-run drops enables and flags
      pulse(8'h01);
      @(posedge clock);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      #1;
      check({7'h00, irq}, 8'h00, "irq after reset");
      rd_reg(sci_pkg::OFS_ENABLES, d);
      check(d, 8'h00, "enables after mid reset");
      rd_reg(sci_pkg::OFS_PENDING, d);
      check(d, 8'h00, "pending after mid reset");
      // unmapped address reads zero
      wr_reg(4'hF, 8'hFF);
      rd_reg(4'hF, d);
      check(d, 8'h00, "unmapped read");
      test_done();
   end

   // cut a hang short
   initial begin
      #100000;
      err_total++;
      test_done();
   end
endmodule
